// *** design/sar_adc_ctrl.sv ***
// Frame, configuration and output coding control of the converter
//
// Overview of operation
// - Each channel keeps its own range: three bipolar and one unipolar.
// - Two mode bits pick single-ended pair, true differential or pseudo differential.
// - The serial clock steps the conversion; there is no other conversion clock.
// - After reset the external reference is selected.
// - Power-down modes come from the programmed power field.
// - Conversion start holds the input and resolves the trial code bit by bit.
// - After reset results are twos complement.
// - Coding bit set gives straight binary, clear gives twos complement.
// - In sequence mode every channel uses the last written coding bit.
// - Step is span over 8192 codes: twelve magnitude bits plus sign.
// - Transitions at whole steps; step size reported per selected range.
// - Frames no faster than 1 MSPS; quicker frames are flagged.
// - After reset inputs are two single-ended channels.
// - The fourteenth rising sclk edge after cs falls returns to tracking.
// - Falling cs stops acquisition, holds the input and starts converting.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_ctrl
    import sar_adc_pkg::*;
(
    input  wire logic              ref_clk,     // 100 MHz system clock
    input  wire logic              rst_n,       // Synchronous reset
    input  wire logic              clk_en,      // Freezes all state while low
    input  wire logic              sclk,        // Serial clock pin
    input  wire logic              cs_n,        // Chip select pin
    input  wire logic              comp_in,     // Comparator result
    input  wire logic              cfg_wr,      // Control write strobe
    input  wire logic [1:0]        cfg_mode,    // Input configuration
    input  wire logic [1:0]        cfg_rng0,    // Range, channel 0
    input  wire logic [1:0]        cfg_rng1,    // Range, channel 1
    input  wire logic              cfg_ref_int, // 1 = on-chip reference
    input  wire logic [1:0]        cfg_pwr,     // Power mode
    input  wire logic              cfg_coding,  // 1 = straight binary
    input  wire logic              cfg_seq,     // Alternate channels per frame
    input  wire logic              err_clr,     // Clears error flags
    output logic                   hold,        // Input held, converting
    output logic                   pwr_down,    // Analog power-down request
    output logic                   ref_int,     // On-chip reference in use
    output logic [1:0]             mode_act,    // Mode in use
    output logic [1:0]             range_act,   // Range of channel in conversion
    output logic                   chan,        // Channel in conversion
    output logic [11:0]            step_uv,     // Step size of active range
    output logic [DATA_W-1:0]      result,      // Coded result
    output logic                   result_vld,  // Pulse when result updates
    output logic                   rate_err,    // Frame came too soon
    output logic                   mode_err     // Reserved mode was written
);
    typedef struct packed {
        logic [1:0]        cs_sy;
        logic [1:0]        sclk_sy;
        logic              sclk_q;
        logic              cs_q;
        conv_state_e       state;
        logic [EDGE_W-1:0] edges;
        logic [1:0]        p_mode;
        logic [1:0]        p_rng0;
        logic [1:0]        p_rng1;
        logic              p_ref;
        logic [1:0]        p_pwr;
        logic              p_coding;
        logic              p_seq;
        logic [1:0]        a_mode;
        logic [1:0]        a_rng0;
        logic [1:0]        a_rng1;
        logic              a_ref;
        logic [1:0]        a_pwr;
        logic              a_coding;
        logic              a_seq;
        logic              chan;
        logic [DATA_W-1:0] result;
        logic              vld;
        logic [GAP_W-1:0]  gap;
        logic              rate_err;
        logic              mode_err;
    } ctrl_s;

    if (CODES != (1 << DATA_W) || FRAME_CYC >= (1 << GAP_W)) begin : g_bad_consts
        $error("package constants inconsistent");
    end

    function automatic logic [11:0] step_of(input logic [1:0] rng);
        case (rng)
            RNG_PM10:  step_of = STEP_UV_PM10;
            RNG_PM5:   step_of = STEP_UV_PM5;
            RNG_PM2P5: step_of = STEP_UV_PM2P5;
            default:   step_of = STEP_UV_UNI10;
        endcase
    endfunction

    sar_if cif ();

    ctrl_s r, n;
    logic  sclk_rise;
    logic  cs_edge_fall;
    logic  cs_edge_rise;

    // Edges are taken from the second synchroniser stage only
    assign sclk_rise    = r.sclk_sy[1] && !r.sclk_q;
    assign cs_edge_fall = !r.cs_sy[1] && r.cs_q;
    assign cs_edge_rise = r.cs_sy[1] && !r.cs_q;

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------

    always_comb begin
        n          = r;
        n.cs_sy    = {r.cs_sy[0], cs_n};
        n.sclk_sy  = {r.sclk_sy[0], sclk};
        n.sclk_q   = r.sclk_sy[1];
        n.cs_q     = r.cs_sy[1];
        n.vld      = 1'b0;
        cif.start  = 1'b0;
        cif.step   = 1'b0;
        cif.comp   = comp_in;
        // Counts down from frame start; zero after reset so a first frame is never flagged
        if (r.gap != '0) begin
            n.gap = r.gap - 1'b1;
        end
        // Pending copy follows every write; reserved mode is refused
        if (cfg_wr) begin
            if (cfg_mode != MODE_RSVD) begin
                n.p_mode = cfg_mode;
            end
            n.p_rng0   = cfg_rng0;
            n.p_rng1   = cfg_rng1;
            n.p_ref    = cfg_ref_int;
            n.p_pwr    = cfg_pwr;
            n.p_coding = cfg_coding;
            n.p_seq    = cfg_seq;
        end
        if (err_clr) begin
            n.rate_err = 1'b0;
            n.mode_err = 1'b0;
        end
        // Error sets placed after the clear so that a set wins
        if (cfg_wr && cfg_mode == MODE_RSVD) begin
            n.mode_err = 1'b1;
        end
        case (r.state)
            ST_TRACK: begin
                if (cs_edge_fall) begin
                    // Latch configuration at frame start only
                    n.a_mode   = r.p_mode;
                    n.a_rng0   = r.p_rng0;
                    n.a_rng1   = r.p_rng1;
                    n.a_ref    = r.p_ref;
                    n.a_pwr    = r.p_pwr;
                    n.a_coding = r.p_coding;
                    n.a_seq    = r.p_seq;
                    if (r.p_seq && r.p_mode == MODE_SE && r.a_seq) begin
                        n.chan = !r.chan;
                    end else begin
                        n.chan = 1'b0;
                    end
                    n.state   = ST_CONV;
                    n.edges   = '0;
                    n.gap     = GAP_W'(FRAME_CYC - 1);
                    cif.start = 1'b1;
                    if (r.gap != '0) begin
                        n.rate_err = 1'b1;
                    end
                end
            end
            ST_CONV: begin
                if (cs_edge_rise) begin
                    // Frame aborted: back to tracking without a result
                    n.state = ST_TRACK;
                end else if (sclk_rise) begin
                    n.edges = r.edges + 1'b1;
                    if (r.edges == EDGE_END - 1'b1) begin
                        n.state = ST_TRACK;
                        n.vld   = 1'b1;
                        if (r.a_coding == CODE_TWOS) begin
                            n.result = {~cif.code[DATA_W-1], cif.code[DATA_W-2:0]};
                        end else begin
                            n.result = cif.code;
                        end
                    end else begin
                        cif.step = 1'b1;
                    end
                end
            end
            default: n.state = ST_TRACK;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else if (clk_en) begin
            r <= n;
        end
    end

    sar_step u_sar (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .cif     (cif)
    );

    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    assign hold       = (r.state == ST_CONV);
    // Auto modes save power only while tracking between frames
    assign pwr_down   = (r.a_pwr == PWR_FULL)
                     || (r.a_pwr != PWR_NORMAL && r.state == ST_TRACK);
    assign ref_int    = r.a_ref;
    assign mode_act   = r.a_mode;
    assign chan       = r.chan;
    assign range_act  = r.chan ? r.a_rng1 : r.a_rng0;
    assign step_uv    = step_of(range_act);
    assign result     = r.result;
    assign result_vld = r.vld;
    assign rate_err   = r.rate_err;
    assign mode_err   = r.mode_err;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    a_hold_on_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && r.state == ST_TRACK && cs_edge_fall |=> hold && r.edges == '0)
        else $error("input not held at chip select fall");
    a_track_at_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && hold && !cs_edge_rise && sclk_rise && r.edges == EDGE_END - 4'h1
        |=> !hold && result_vld)
        else $error("no return to tracking on fourteenth edge");
    a_step_per_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hold && !cs_edge_rise && sclk_rise && r.edges < EDGE_END - 4'h1 |-> cif.step)
        else $error("serial clock edge did not step conversion");
    a_coding_twos: assert property (@(posedge ref_clk) disable iff (!rst_n)
        result_vld && r.a_coding == CODE_TWOS |-> result == {~cif.code[12], cif.code[11:0]})
        else $error("twos complement coding wrong");
    a_coding_binary: assert property (@(posedge ref_clk) disable iff (!rst_n)
        result_vld && r.a_coding != CODE_TWOS |-> result == cif.code)
        else $error("straight binary coding wrong");
    a_cfg_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hold |=> $stable(mode_act) && $stable(r.a_coding) && $stable(ref_int))
        else $error("configuration changed inside a frame");
    a_reset_defaults: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(rst_n) |-> mode_act == MODE_SE && ref_int == REF_EXT && r.a_coding == CODE_TWOS)
        else $error("reset configuration wrong");
    a_rate_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && !hold && cs_edge_fall && r.gap != '0 |=> rate_err [*2])
        else $error("fast frame not flagged");
    a_mode_refused: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && cfg_wr && cfg_mode == MODE_RSVD |=> mode_err && $stable(r.p_mode))
        else $error("reserved mode accepted");
endmodule // sar_adc_ctrl
`default_nettype wire

// *** pkg/sar_adc_pkg.sv ***
// Shared constants and types for the converter control logic
package sar_adc_pkg;

    //--------------------------------------------------------------
    // Data format
    //--------------------------------------------------------------
    localparam int          DATA_W   = 13;         // 12 magnitude bits plus sign
    localparam int          CODES    = 8192;       // Codes across the full span
    localparam int          EDGE_W   = 4;
    localparam logic [3:0]  EDGE_END = 4'hE;       // Rising sclk edge that ends a frame
    localparam logic [3:0]  MSB_IDX  = 4'hC;

    //--------------------------------------------------------------
    // Configuration field encodings (all reset values are zero)
    //--------------------------------------------------------------
    localparam logic [1:0]  MODE_SE     = 2'h0;    // Two single-ended channels
    localparam logic [1:0]  MODE_DIFF   = 2'h1;    // One true differential pair
    localparam logic [1:0]  MODE_PSEUDO = 2'h2;    // One pseudo differential pair
    localparam logic [1:0]  MODE_RSVD   = 2'h3;
    localparam logic [1:0]  RNG_PM10    = 2'h0;
    localparam logic [1:0]  RNG_PM5     = 2'h1;
    localparam logic [1:0]  RNG_PM2P5   = 2'h2;
    localparam logic [1:0]  RNG_UNI10   = 2'h3;
    localparam logic [1:0]  PWR_NORMAL  = 2'h0;
    localparam logic [1:0]  PWR_AUTO_SB = 2'h1;    // Standby while tracking
    localparam logic [1:0]  PWR_AUTO_PD = 2'h2;    // Power-down while tracking
    localparam logic [1:0]  PWR_FULL    = 2'h3;
    localparam logic        REF_EXT     = 1'b0;
    localparam logic        CODE_TWOS   = 1'b0;

    //--------------------------------------------------------------
    // Step size per range, in microvolts
    //--------------------------------------------------------------
    localparam logic [11:0] STEP_UV_PM10  = 12'h989;  // 2441
    localparam logic [11:0] STEP_UV_PM5   = 12'h4C4;  // 1220
    localparam logic [11:0] STEP_UV_PM2P5 = 12'h262;  // 610
    localparam logic [11:0] STEP_UV_UNI10 = 12'h4C4;  // 1220

    //--------------------------------------------------------------
    // Timing
    //--------------------------------------------------------------
    localparam int CLK_NS    = 10;
    localparam int FRAME_NS  = 1000;                   // 1 MSPS
    localparam int FRAME_CYC = (FRAME_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_W     = 7;

    typedef enum logic {ST_TRACK, ST_CONV} conv_state_e;

endpackage

// *** pkg/sar_if.sv ***
// Carrier between the frame controller and the approximation register
`timescale 1ns/1ns
`default_nettype none
interface sar_if;
    import sar_adc_pkg::*;
    logic              start;   // Begin a conversion, load mid trial
    logic              step;    // Resolve one bit
    logic              comp;    // Comparator: input above trial code
    logic [DATA_W-1:0] code;    // Trial code, final when done
    logic              done;

    modport ctl (output start, output step, output comp, input code, input done);
    modport sar (input start, input step, input comp, output code, output done);
endinterface // sar_if
`default_nettype wire

// *** design/sar_step.sv ***
// Successive approximation register, one bit resolved per step
`timescale 1ns/1ns
`default_nettype none
module sar_step
    import sar_adc_pkg::*;
(
    input  wire logic ref_clk,   // System clock
    input  wire logic rst_n,     // Synchronous reset
    input  wire logic clk_en,    // Freezes state while low
    sar_if.sar        cif        // Controller side
);
    typedef struct packed {
        logic [DATA_W-1:0] code;
        logic [EDGE_W-1:0] idx;
        logic              done;
    } sar_s;

    sar_s r, n;

    always_comb begin
        n = r;
        if (cif.start) begin
            n.code          = '0;
            n.code[MSB_IDX] = 1'b1;
            n.idx           = MSB_IDX;
            n.done          = 1'b0;
        end else if (cif.step && !r.done) begin
            // Drop the trial bit when the input is below it, then try the next
            n.code[r.idx] = cif.comp;
            if (r.idx == '0) begin
                n.done = 1'b1;
            end else begin
                n.code[r.idx - 1'b1] = 1'b1;
                n.idx                = r.idx - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else if (clk_en) begin
            r <= n;
        end
    end

    assign cif.code = r.code;
    assign cif.done = r.done;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    a_sar_mid_trial: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && cif.start |=> r.code == (13'h1000) && !r.done)
        else $error("trial code not loaded at mid scale");
    a_sar_last_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && cif.step && !cif.start && !r.done && r.idx == '0 |=> r.done)
        else $error("conversion not done after last bit");
endmodule // sar_step
`default_nettype wire

// *** sim/host_link.sv ***
// Host side of the serial link: frames cs_n and sclk and models the comparator
`timescale 1ns/1ns
`default_nettype none
module host_link (
    input  wire logic        go,        // Start one frame
    input  wire logic [3:0]  n_edges,   // Rising sclk edges in the frame
    input  wire logic [12:0] code,      // Raw code the comparator steers to
    output logic             cs_n,      // Chip select, active low
    output logic             sclk,      // Serial clock, still outside frames
    output logic             comp_in,   // Comparator decision per step
    output logic             busy       // Frame in progress
);
    //------------------------------------------------------------
    // Frame generator
    //------------------------------------------------------------
    initial begin
        cs_n    = 1'b1;
        sclk    = 1'b0;
        comp_in = 1'b0;
        busy    = 1'b0;
    end

    // The odd 37 ns offset keeps the link edges off the ref_clk edges
    // Frames last well over 1 us, so the host never exceeds the rate unless aborted
    always @(posedge go) begin
        busy = 1'b1;
        #37;
        cs_n = 1'b0;
        #80;
        for (int k = 0; k < n_edges; k++) begin
            sclk    = 1'b1;
            // Decision for bit k: keep the trial bit when the input is above it
            comp_in = (k < 13) ? code[12 - k] : ~comp_in;
            #80;
            sclk    = 1'b0;
            #80;
        end
        #40;
        cs_n    = 1'b1;
        // Released line: show the inverse so a stale value is never mistaken
        comp_in = ~comp_in;
        #300;
        busy    = 1'b0;
    end
endmodule // host_link
`default_nettype wire

// *** sim/bipolar_sar_adc_config_and_coding_tb_top.sv ***
// Self-checking testbench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module bipolar_sar_adc_config_and_coding_tb_top;
    import sar_adc_pkg::*;

    logic              ref_clk, rst_n, cfg_wr, cfg_ref_int, cfg_coding, cfg_seq, err_clr;
    logic              clk_en;
    logic [1:0]        cfg_mode, cfg_rng0, cfg_rng1, cfg_pwr;
    logic              sclk, cs_n, comp_in, busy, go;
    logic [3:0]        lnk_edges;
    logic [12:0]       lnk_code;
    logic              hold, pwr_down, ref_int, chan, result_vld, rate_err, mode_err;
    logic [1:0]        mode_act, range_act;
    logic [11:0]       step_uv;
    logic [DATA_W-1:0] result;
    int                err_count, n_tests, v;
    logic [11:0]       steps [4];

    sar_adc_ctrl sar_adc_ctrl_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n),
        .comp_in(comp_in), .cfg_wr(cfg_wr), .cfg_mode(cfg_mode), .cfg_rng0(cfg_rng0),
        .cfg_rng1(cfg_rng1), .cfg_ref_int(cfg_ref_int), .cfg_pwr(cfg_pwr),
        .cfg_coding(cfg_coding), .cfg_seq(cfg_seq), .err_clr(err_clr), .hold(hold),
        .pwr_down(pwr_down), .ref_int(ref_int), .mode_act(mode_act), .range_act(range_act),
        .chan(chan), .step_uv(step_uv), .result(result), .result_vld(result_vld),
        .rate_err(rate_err), .mode_err(mode_err)
    );

    host_link host_link_i (
        .go(go), .n_edges(lnk_edges), .code(lnk_code), .cs_n(cs_n), .sclk(sclk),
        .comp_in(comp_in), .busy(busy)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    //------------------------------------------------------------
    // Access tasks
    //------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Checks: %0d, mismatches: %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cfg(input logic [1:0] md, input logic [1:0] r0, input logic [1:0] r1,
                       input logic ri, input logic [1:0] pw, input logic cd, input logic sq);
        @(posedge ref_clk);
        cfg_mode    <= md;
        cfg_rng0    <= r0;
        cfg_rng1    <= r1;
        cfg_ref_int <= ri;
        cfg_pwr     <= pw;
        cfg_coding  <= cd;
        cfg_seq     <= sq;
        cfg_wr      <= 1'b1;
        @(posedge ref_clk);
        cfg_wr      <= 1'b0;
        @(negedge ref_clk);
    endtask

    // Runs one frame and counts result pulses; a hung frame ends the run
    task automatic frame(input logic [3:0] edges, input logic [12:0] code, output int vld_n);
        int t;
        vld_n = 0;
        @(posedge ref_clk);
        lnk_edges <= edges;
        lnk_code  <= code;
        go        <= 1'b1;
        @(posedge ref_clk);
        go        <= 1'b0;
        for (t = 0; t < 3000 && busy; t++) begin
            @(negedge ref_clk);
            if (result_vld === 1'b1) vld_n++;
        end
        if (busy) begin
            err_count++;
            end_of_test();
        end
    endtask

    //------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------
    initial begin
        err_count = 0;
        n_tests   = 0;
        steps     = '{STEP_UV_PM10, STEP_UV_PM5, STEP_UV_PM2P5, STEP_UV_UNI10};
        {rst_n, cfg_wr, cfg_ref_int, cfg_coding, cfg_seq, err_clr, go} = '0;
        {cfg_mode, cfg_rng0, cfg_rng1, cfg_pwr} = '0;
        clk_en    = 1'b1;
        lnk_edges = 4'hE;
        lnk_code  = 13'h0000;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(negedge ref_clk);
        chk(ref_int, 1'b0);
        chk(mode_act, MODE_SE);
        chk({hold, pwr_down, result_vld, rate_err, mode_err}, 5'h00);
        chk(step_uv, 12'h989);
        // Default coding is twos complement: raw code with MSB inverted
        frame(4'hE, 13'h0A5C, v);
        chk(v, 1);
        chk(result, 13'h1A5C);
        chk(hold, 1'b0);
        // The host must write the reference bit to leave external operation
        cfg(MODE_DIFF, RNG_PM5, RNG_PM10, 1'b1, PWR_NORMAL, 1'b1, 1'b0);
        chk({ref_int, mode_act}, {1'b0, MODE_SE});
        frame(4'hE, 13'h1F03, v);
        chk(result, 13'h1F03);
        chk({ref_int, mode_act}, {1'b1, MODE_DIFF});
        chk(step_uv, 12'h4C4);
        cfg(MODE_PSEUDO, RNG_PM5, RNG_PM10, 1'b1, PWR_NORMAL, 1'b1, 1'b0);
        frame(4'hE, 13'h0001, v);
        chk(mode_act, MODE_PSEUDO);
        // Every range and every power mode, one frame each
        for (int i = 0; i < 4; i++) begin
            cfg(MODE_SE, 2'(i), 2'(3 - i), 1'b0, 2'(i), 1'b0, 1'b0);
            frame(4'hE, 13'(12'hFFF + i), v);
            chk({chan, range_act}, {1'b0, 2'(i)});
            chk(step_uv, steps[i]);
            chk(pwr_down, i != 0);
            chk(result, 13'(12'hFFF + i) ^ 13'h1000);
        end
        chk(rate_err, 1'b0);
        // Reserved mode is refused and flagged
        cfg(MODE_RSVD, RNG_PM10, RNG_PM2P5, 1'b0, PWR_NORMAL, 1'b1, 1'b1);
        chk(mode_err, 1'b1);
        // Sequence: first frame stays on channel 0, then alternates
        frame(4'hE, 13'h1234, v);
        chk({mode_act, chan, range_act}, {MODE_SE, 1'b0, RNG_PM10});
        frame(4'hE, 13'h0ABC, v);
        chk({chan, range_act, step_uv}, {1'b1, RNG_PM2P5, STEP_UV_PM2P5});
        chk(result, 13'h0ABC);
        frame(4'hE, 13'h1111, v);
        chk({chan, result}, {1'b0, 13'h1111});
        // Aborted frame gives no result; the quick restart is flagged but still runs
        frame(4'h2, 13'h0F0F, v);
        chk(v, 0);
        chk(hold, 1'b0);
        frame(4'hE, 13'h0F0F, v);
        chk({v[0], rate_err, result}, {1'b1, 1'b1, 13'h0F0F});
        @(posedge ref_clk);
        err_clr <= 1'b1;
        @(posedge ref_clk);
        err_clr <= 1'b0;
        @(negedge ref_clk);
        chk({rate_err, mode_err}, 2'h0);
        // Clock enable low: a reserved write must leave no trace
        @(posedge ref_clk);
        clk_en <= 1'b0;
        cfg(MODE_RSVD, RNG_PM10, RNG_PM10, 1'b0, PWR_NORMAL, 1'b0, 1'b0);
        chk(mode_err, 1'b0);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        end_of_test();
    end
endmodule // bipolar_sar_adc_config_and_coding_tb_top
`default_nettype wire
